// ===== src/btc_batch_total_ctrl.sv
// batch and total flow counter control
`timescale 1ns/1ps
`include "btc_params.svh"
module btc_batch_total_ctrl
  import btc_pkg::*;
#(
  parameter int unsigned LEVEL_MIN_CYCLES =
    32'((`BTC_LEVEL_MIN_NS + `BTC_CLK_NS - 64'd1) / `BTC_CLK_NS),
  parameter int unsigned STEP_SEC_CYCLES = 32'(`BTC_STEP_SEC_NS / `BTC_CLK_NS),
  parameter int unsigned STEP_MIN_CYCLES = 32'(`BTC_STEP_MIN_NS / `BTC_CLK_NS)
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic flowValid,
  input wire logic [15:0] flowValue,
  input wire logic belowCutoff,
  input wire btc_cnt_cfg_t batchCfg,
  input wire btc_cnt_cfg_t totalCfg,
  input wire btc_reg_wr_t regWr,
  input wire logic [7:0] regRdAddr,
  input wire logic batchZeroAction,
  input wire logic totalZeroAction,
  input wire logic enterKey,
  input wire logic cancelKey,
  input wire logic sumButton,
  input wire logic autoRestartEnable,
  input wire logic autoRestartMinutes,
  input wire logic [15:0] autoRestartDelay,
  input wire logic batchDone,
  input wire logic progIn,
  input wire btc_action_t inputAction,
  input wire btc_trig_t trigMode,
  output logic [63:0] totalCount,
  output logic [47:0] batchCount,
  output logic [15:0] regRdData,
  output logic confirmPrompt,
  output logic batching,
  output logic batchStart,
  output btc_disp_t batchDisp,
  output btc_disp_t totalDisp
);
  btc_state_t s;
  btc_state_t next_s;
  logic stableHigh;
  logic stableLow;
  logic rise;
  logic fall;
  logic levelMode;
  logic levelAct;
  logic edgeAct;
  logic halted;
  logic clrTotal;
  logic clrBatch;
  logic arFire;
  logic batLevel;
  logic batEdge;
  logic [63:0] totStep;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [19:0] pow10(input logic [2:0] e);
    case (e)
      3'h0: pow10 = 20'h1;
      3'h1: pow10 = 20'ha;
      3'h2: pow10 = 20'h64;
      3'h3: pow10 = 20'h3e8;
      3'h4: pow10 = 20'h2710;
      3'h5: pow10 = 20'h186a0;
      default: pow10 = 20'hf4240;
    endcase
  endfunction : pow10

  // step in millionths of a counter unit, so up to six coefficient decimals fit
  function automatic logic [63:0] scaleStep(input logic [15:0] flow,
                                            input btc_cnt_cfg_t c);
    logic [2:0] dp;
    dp = (c.scaleDp > `BTC_COEF_FRAC_DIGITS) ? `BTC_COEF_FRAC_DIGITS : c.scaleDp;
    scaleStep = 64'(flow) * 64'(c.scaleFactor) * 64'(pow10(`BTC_COEF_FRAC_DIGITS - dp));
  endfunction : scaleStep

  function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // prescaler reload for one 0.1 step of the autoreset delay
  function automatic logic [31:0] stepLoad(input logic minutes);
    stepLoad = (minutes ? STEP_MIN_CYCLES : STEP_SEC_CYCLES) - 32'h1;
  endfunction : stepLoad

  btc_input_qualify #(
    .LEVEL_MIN_CYCLES(LEVEL_MIN_CYCLES)
  ) u_qualify (
    .core_clk(core_clk),
    .nrst(nrst),
    .progIn(progIn),
    .stableHigh(stableHigh),
    .stableLow(stableLow),
    .rise(rise),
    .fall(fall)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    levelMode = (trigMode == TRIG_HIGH) || (trigMode == TRIG_LOW);
    levelAct = levelMode && ((trigMode == TRIG_HIGH) ? stableHigh : stableLow);
    edgeAct = ((trigMode == RISING_EDGE_TRIGGER) && rise)
      || ((trigMode == FALLING_EDGE_TRIGGER) && fall);
    batLevel = (inputAction == ACT_BATCH_ZERO) && levelAct;
    batEdge = (inputAction == ACT_BATCH_ZERO) && edgeAct;
    if (inputAction != ACT_INHIBIT || levelMode) begin
      next_s.inhToggle = 1'b0;
    end else if (edgeAct) begin
      next_s.inhToggle = !s.inhToggle;
    end
    halted = ((inputAction == ACT_INHIBIT) && levelAct) || s.inhToggle;
    totStep = (flowValid && !halted && !belowCutoff) ? scaleStep(flowValue, totalCfg) : 64'h0;

    // autoreset delay: prescaler per 0.1 step, then step count
    arFire = 1'b0;
    if (!autoRestartEnable) begin
      next_s.arWait = 1'b0;
    end else if (batchDone && !s.arWait) begin
      next_s.arWait = 1'b1;
      next_s.arCnt = autoRestartDelay;
      next_s.preCnt = stepLoad(autoRestartMinutes);
    end else if (s.arWait) begin
      if (s.preCnt != 32'h0) begin
        next_s.preCnt = s.preCnt - 32'h1;
      end else if (s.arCnt != 16'h0) begin
        next_s.arCnt = s.arCnt - 16'h1;
        next_s.preCnt = stepLoad(autoRestartMinutes);
      end else begin
        arFire = 1'b1;
        next_s.arWait = 1'b0;
      end
    end

    clrTotal = regWr.stb && (regWr.data == `BTC_ZERO_WORD)
      && inRange(regWr.addr, `BTC_TOT_FIRST, `BTC_TOT_LAST);
    clrBatch = regWr.stb && (regWr.data == `BTC_ZERO_WORD)
      && inRange(regWr.addr, `BTC_BAT_FIRST, `BTC_BAT_LAST);
    clrTotal = clrTotal || (sumButton && totalCfg.buttonZeroAllow);
    clrBatch = clrBatch || (sumButton && batchCfg.buttonZeroAllow);
    clrTotal = clrTotal || ((inputAction == ACT_TOTAL_ZERO) && (levelAct || edgeAct));
    clrBatch = clrBatch || batLevel || batEdge || arFire;

    // menu confirmation; a new request while asking is ignored
    next_s.prompt = 1'b0;
    case (s.menu)
      MENU_IDLE: begin
        if (batchZeroAction) begin
          next_s.menu = MENU_ASK_BATCH;
        end else if (totalZeroAction) begin
          next_s.menu = MENU_ASK_TOTAL;
        end
      end
      MENU_ASK_BATCH: begin
        if (enterKey) begin
          clrBatch = 1'b1;
          next_s.menu = MENU_IDLE;
        end else if (cancelKey) begin
          next_s.menu = MENU_IDLE;
        end
      end
      MENU_ASK_TOTAL: begin
        if (enterKey) begin
          clrTotal = 1'b1;
          next_s.menu = MENU_IDLE;
        end else if (cancelKey) begin
          next_s.menu = MENU_IDLE;
        end
      end
      default: begin
        next_s.menu = MENU_IDLE;
      end
    endcase
    next_s.prompt = (next_s.menu != MENU_IDLE);

    if (batLevel) begin
      next_s.batching = 1'b0;
    end else if (batEdge || arFire || ((inputAction == ACT_BATCH_ZERO) && levelMode)) begin
      next_s.batching = 1'b1;
    end
    next_s.batchStart = next_s.batching && (!s.batching || batEdge || arFire);

    next_s.totalAcc = s.totalAcc + totStep;
    if (flowValid && !halted) begin
      if (s.batching) begin
        next_s.batchAcc = 48'(s.batchAcc + 48'(scaleStep(flowValue, batchCfg)));
      end
    end
    // a clear in the same cycle as a flow step wins: the counter restarts at zero
    if (clrTotal) begin
      next_s.totalAcc = '0;
    end
    if (clrBatch) begin
      next_s.batchAcc = '0;
    end

    // total scale decimals feed only the total step, never the total display
    next_s.totalDisp = '{prec: totalCfg.prec, kiloUnits: totalCfg.kiloUnits};
    next_s.batchDisp = '{prec: batchCfg.prec, kiloUnits: batchCfg.kiloUnits};

    case (regRdAddr)
      `BTC_TOT_FIRST: next_s.rdData = s.totalAcc[15:0];
      `BTC_TOT_FIRST + 8'h1: next_s.rdData = s.totalAcc[31:16];
      `BTC_TOT_FIRST + 8'h2: next_s.rdData = s.totalAcc[47:32];
      `BTC_TOT_LAST: next_s.rdData = s.totalAcc[63:48];
      `BTC_BAT_FIRST: next_s.rdData = s.batchAcc[15:0];
      `BTC_BAT_FIRST + 8'h1: next_s.rdData = s.batchAcc[31:16];
      `BTC_BAT_LAST: next_s.rdData = s.batchAcc[47:32];
      default: next_s.rdData = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '{menu: MENU_IDLE, batching: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign totalCount = s.totalAcc;
  assign batchCount = s.batchAcc;
  assign regRdData = s.rdData;
  assign confirmPrompt = s.prompt;
  assign batching = s.batching;
  assign batchStart = s.batchStart;
  assign batchDisp = s.batchDisp;
  assign totalDisp = s.totalDisp;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_reg_batch;
    regWr.stb && regWr.data == 16'h0 && regWr.addr >= 8'h0d && regWr.addr <= 8'h0f
      |=> batchCount == 48'h0;
  endproperty
  a_reg_batch: assert property (p_reg_batch) else $error("batch not zeroed");

  property p_reg_total;
    regWr.stb && regWr.data == 16'h0 && regWr.addr >= 8'h09 && regWr.addr <= 8'h0c
      |=> totalCount == 64'h0;
  endproperty
  a_reg_total: assert property (p_reg_total) else $error("total not zeroed");

  sequence s_ask_batch;
    batchZeroAction && s.menu == MENU_IDLE ##1 confirmPrompt;
  endsequence
  property p_menu_batch;
    s_ask_batch ##0 (enterKey && s.menu == MENU_ASK_BATCH)
      |=> batchCount == 48'h0 && !confirmPrompt;
  endproperty
  a_menu_batch: assert property (p_menu_batch) else $error("menu batch clear failed");

  property p_menu_total;
    s.menu == MENU_ASK_TOTAL && cancelKey && !enterKey && !clrTotal
      |=> !confirmPrompt && totalCount == $past(totalCount) + $past(totStep);
  endproperty
  a_menu_total: assert property (p_menu_total) else $error("cancel changed total");

  property p_button;
    sumButton && batchCfg.buttonZeroAllow && totalCfg.buttonZeroAllow
      |=> batchCount == 48'h0 && totalCount == 64'h0;
  endproperty
  a_button: assert property (p_button) else $error("button clear failed");

  property p_inhibit_level;
    inputAction == ACT_INHIBIT && levelAct && !clrTotal |=> totalCount == $past(totalCount);
  endproperty
  a_inhibit_level: assert property (p_inhibit_level) else $error("counted in inhibit");

  property p_inhibit_edge;
    inputAction == ACT_INHIBIT && !levelMode && edgeAct |=> s.inhToggle != $past(s.inhToggle);
  endproperty
  a_inhibit_edge: assert property (p_inhibit_edge) else $error("inhibit did not toggle");

  property p_batch_level;
    batLevel |=> !batching && batchCount == 48'h0 ##1 !batching || !batLevel;
  endproperty
  a_batch_level: assert property (p_batch_level) else $error("level batch hold broken");

  property p_autoreset;
    arFire |=> batchStart && batching && batchCount == 48'h0;
  endproperty
  a_autoreset: assert property (p_autoreset) else $error("autoreset did not restart");

  property p_autoreset_off;
    !autoRestartEnable |=> !s.arWait;
  endproperty
  a_autoreset_off: assert property (p_autoreset_off) else $error("autoreset ran while off");

  property p_edge_batch;
    batEdge |=> batchStart && batching && batchCount == 48'h0;
  endproperty
  a_edge_batch: assert property (p_edge_batch) else $error("edge batch restart failed");

  property p_cutoff;
    belowCutoff && !clrTotal |=> totalCount == $past(totalCount);
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("total counted under cutoff");

  property p_batch_gate;
    !batching && !clrBatch |=> batchCount == $past(batchCount);
  endproperty
  a_batch_gate: assert property (p_batch_gate) else $error("batch counted while stopped");

  property p_prompt;
    s.menu == MENU_IDLE && !batchZeroAction && !totalZeroAction |=> !confirmPrompt;
  endproperty
  a_prompt: assert property (p_prompt) else $error("prompt without request");

  property p_disp;
    1'b1 |=> batchDisp.prec == $past(batchCfg.prec)
      && totalDisp.kiloUnits == $past(totalCfg.kiloUnits);
  endproperty
  a_disp: assert property (p_disp) else $error("display setting not passed");
endmodule : btc_batch_total_ctrl

// ===== src/btc_input_qualify.sv
// programmable input synchroniser, edge detector and level persistence filter
`timescale 1ns/1ps
module btc_input_qualify
  import btc_pkg::*;
#(
  parameter int unsigned LEVEL_MIN_CYCLES = 200000
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic progIn,
  output logic stableHigh,
  output logic stableLow,
  output logic rise,
  output logic fall
);
  btc_qual_st_t s;
  btc_qual_st_t next_s;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.syncA = progIn;
    next_s.syncB = s.syncA;
    next_s.prevB = s.syncB;
    if (s.syncB != s.prevB) begin
      next_s.holdCnt = '0;
    end else if (s.holdCnt < LEVEL_MIN_CYCLES) begin
      next_s.holdCnt = s.holdCnt + 32'h1;
    end
    // only a level that outlived the minimum counts as active
    next_s.stableHigh = (s.syncB == s.prevB) && (next_s.holdCnt >= LEVEL_MIN_CYCLES)
      && s.syncB;
    next_s.stableLow = (s.syncB == s.prevB) && (next_s.holdCnt >= LEVEL_MIN_CYCLES)
      && !s.syncB;
    next_s.rise = s.syncB && !s.prevB;
    next_s.fall = !s.syncB && s.prevB;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign stableHigh = s.stableHigh;
  assign stableLow = s.stableLow;
  assign rise = s.rise;
  assign fall = s.fall;

  // ****************************************
  // checks
  // ****************************************
  property p_restart;
    @(posedge core_clk) disable iff (!nrst)
    (s.syncB != s.prevB) |=> (s.holdCnt == 32'h0) ##1 (!s.stableHigh && !s.stableLow);
  endproperty
  a_restart: assert property (p_restart) else $error("hold count not restarted");

  property p_stable;
    @(posedge core_clk) disable iff (!nrst)
    (s.stableHigh || s.stableLow) |-> (s.holdCnt >= LEVEL_MIN_CYCLES);
  endproperty
  a_stable: assert property (p_stable) else $error("level taken too early");

  property p_edge;
    @(posedge core_clk) disable iff (!nrst)
    $rose(s.syncB) |=> s.rise;
  endproperty
  a_edge: assert property (p_edge) else $error("rising edge missed");
endmodule : btc_input_qualify

// ===== src/btc_params.svh
// offsets, field values and timing figures for the batch/total counter block
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH

`define BTC_TOT_FIRST 8'h09
`define BTC_TOT_LAST 8'h0c
`define BTC_BAT_FIRST 8'h0d
`define BTC_BAT_LAST 8'h0f
`define BTC_ZERO_WORD 16'h0000
`define BTC_COEF_FRAC_DIGITS 3'h6
`define BTC_CLK_NS 64'd25
`define BTC_LEVEL_MIN_NS 64'd5000000
`define BTC_STEP_SEC_NS 64'd100000000
`define BTC_STEP_MIN_NS 64'd6000000000

`endif

// ===== src/btc_pkg.sv
// types shared by the batch/total counter block
package btc_pkg;
  typedef enum logic [1:0] {MENU_IDLE, MENU_ASK_BATCH, MENU_ASK_TOTAL} btc_menu_t;
  typedef enum logic [1:0] {
    INPUT_ACTION_OFF, ACT_TOTAL_ZERO, ACT_BATCH_ZERO, ACT_INHIBIT
  } btc_action_t;
  typedef enum logic [1:0] {
    TRIG_HIGH, TRIG_LOW, RISING_EDGE_TRIGGER, FALLING_EDGE_TRIGGER
  } btc_trig_t;
  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [15:0] data;
  } btc_reg_wr_t;
  typedef struct packed {
    logic [19:0] scaleFactor;
    logic [2:0] scaleDp;
    logic [1:0] prec;
    logic kiloUnits;
    logic buttonZeroAllow;
  } btc_cnt_cfg_t;
  typedef struct packed {
    logic [1:0] prec;
    logic kiloUnits;
  } btc_disp_t;
  typedef struct packed {
    logic syncA;
    logic syncB;
    logic prevB;
    logic [31:0] holdCnt;
    logic stableHigh;
    logic stableLow;
    logic rise;
    logic fall;
  } btc_qual_st_t;
  typedef struct packed {
    logic [63:0] totalAcc;
    logic [47:0] batchAcc;
    btc_menu_t menu;
    logic prompt;
    logic batching;
    logic batchStart;
    logic inhToggle;
    logic arWait;
    logic [15:0] arCnt;
    logic [31:0] preCnt;
    logic [15:0] rdData;
    btc_disp_t batchDisp;
    btc_disp_t totalDisp;
  } btc_state_t;
endpackage : btc_pkg

// ===== testbench/btc_host_model.sv
// serial host and programmable input source for the counter bench
`timescale 1ns/1ps
module btc_host_model
  import btc_pkg::*;
(
  input wire logic core_clk,
  output btc_reg_wr_t regWr,
  output logic progIn
);
  initial begin
    regWr = '0;
    progIn = 1'h0;
  end
  // one write, held for exactly one taken edge, then strobe drops and address and data are inverted
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    regWr = '{stb: 1'h1, addr: a, data: d};
    @(posedge core_clk);
    #1;
    regWr = '{stb: 1'h0, addr: ~a, data: ~d};
  endtask : write_word
  // level tests hold the pin both shorter and longer than the qualify time
  task automatic drive_pin(input logic v, input int n);
    @(posedge core_clk);
    #1;
    progIn = v;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : drive_pin
endmodule : btc_host_model

// ===== testbench/testbench.sv
// self-checking bench for the batch/total counter control
`timescale 1ns/1ps
module testbench
  import btc_pkg::*;
  ;
  localparam int LVL = 20;
  localparam int SSEC = 10;
  localparam int SMIN = 30;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic flowValid = 1'h0;
  logic [15:0] flowValue = '0;
  logic belowCutoff = 1'h0;
  btc_cnt_cfg_t batchCfg = '0;
  btc_cnt_cfg_t totalCfg = '0;
  btc_reg_wr_t regWr;
  logic [7:0] regRdAddr = '0;
  logic batchZeroAction = 1'h0, totalZeroAction = 1'h0, enterKey = 1'h0, cancelKey = 1'h0;
  logic sumButton = 1'h0, autoRestartEnable = 1'h0, autoRestartMinutes = 1'h0;
  logic [15:0] autoRestartDelay = '0;
  logic batchDone = 1'h0;
  logic progIn;
  btc_action_t inputAction = INPUT_ACTION_OFF;
  btc_trig_t trigMode = TRIG_HIGH;
  logic [63:0] totalCount;
  logic [47:0] batchCount;
  logic [15:0] regRdData;
  logic confirmPrompt, batching, batchStart;
  btc_disp_t batchDisp, totalDisp;
  int seed = 32'hd8f2bcdc;
  int bad_count = 0;
  int total_checks = 0;
  int starts = 0;
  int s0;
  logic [63:0] expT = '0;
  logic [47:0] expB = '0;

  btc_batch_total_ctrl #(
    .LEVEL_MIN_CYCLES(LVL), .STEP_SEC_CYCLES(SSEC), .STEP_MIN_CYCLES(SMIN)
  ) u_btc_batch_total_ctrl (
    .core_clk, .nrst, .flowValid, .flowValue, .belowCutoff, .batchCfg, .totalCfg,
    .regWr, .regRdAddr, .batchZeroAction, .totalZeroAction, .enterKey, .cancelKey,
    .sumButton, .autoRestartEnable, .autoRestartMinutes, .autoRestartDelay, .batchDone,
    .progIn, .inputAction, .trigMode, .totalCount, .batchCount, .regRdData,
    .confirmPrompt, .batching, .batchStart, .batchDisp, .totalDisp
  );
  btc_host_model u_btc_host_model (.core_clk, .regWr, .progIn);

  always #12.5 core_clk = ~core_clk;
  // sampled away from the launching edge to avoid a race
  always @(negedge core_clk) if (batchStart === 1'h1) starts++;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [63:0] inc_of(logic [15:0] f, btc_cnt_cfg_t c);
    logic [63:0] p;
    p = 64'(f) * 64'(c.scaleFactor);
    for (int i = (c.scaleDp > 3'h6) ? 6 : int'(c.scaleDp); i < 6; i++) p = p * 64'ha;
    return p;
  endfunction : inc_of
  function automatic logic [15:0] word_of(int a);
    if (a >= 9 && a <= 12) return 16'(expT >> (16 * (a - 9)));
    if (a >= 13 && a <= 15) return 16'(expB >> (16 * (a - 13)));
    return 16'h0;
  endfunction : word_of
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cmp();
    check(totalCount, expT);
    check(64'(batchCount), 64'(expB));
  endtask : cmp
  task automatic feed(input logic tOn, input logic bOn);
    flowValue = 16'($random(seed)) | 16'h1;
    flowValid = 1'h1;
    step(1);
    flowValid = 1'h0;
    step(1);
    if (tOn && !belowCutoff) expT += inc_of(flowValue, totalCfg);
    if (bOn) expB += 48'(inc_of(flowValue, batchCfg));
  endtask : feed
  task automatic ar_case(input logic en, input logic mn, input int d);
    int n;
    n = (d + 1) * (mn ? SMIN : SSEC);
    feed(1'h1, 1'h1);
    s0 = starts;
    autoRestartEnable = en;
    autoRestartMinutes = mn;
    autoRestartDelay = 16'(d);
    batchDone = 1'h1;
    step(1);
    batchDone = 1'h0;
    step(n - 3);
    cmp();
    step(6);
    if (en) expB = '0;
    cmp();
    check(64'(starts - s0), 64'(en));
  endtask : ar_case
  task automatic lvl_case(input btc_action_t act, input logic hi);
    inputAction = INPUT_ACTION_OFF;
    trigMode = hi ? TRIG_HIGH : TRIG_LOW;
    u_btc_host_model.drive_pin(!hi, LVL + 5);
    inputAction = act;
    feed(1'h1, 1'h1);
    u_btc_host_model.drive_pin(hi, LVL / 2);
    u_btc_host_model.drive_pin(!hi, 2);
    u_btc_host_model.drive_pin(hi, LVL / 2);
    cmp();
    u_btc_host_model.drive_pin(hi, LVL);
    if (act == ACT_BATCH_ZERO) expB = '0;
    if (act == ACT_TOTAL_ZERO) expT = '0;
    feed(act == INPUT_ACTION_OFF || act == ACT_BATCH_ZERO,
         act == INPUT_ACTION_OFF || act == ACT_TOTAL_ZERO);
    cmp();
    check(64'(batching), 64'(act != ACT_BATCH_ZERO));
    u_btc_host_model.drive_pin(!hi, LVL + 5);
    check(64'(batching), 64'h1);
    feed(1'h1, 1'h1);
    cmp();
  endtask : lvl_case
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(5);
    nrst = 1'h1;
    step(1);
    cmp();
    check(64'({confirmPrompt, batching, batchStart}), 64'h2);
    for (int i = 0; i < 40; i++) begin
      flowValid = 1'($random(seed));
      flowValue = 16'($random(seed));
      belowCutoff = 1'($random(seed));
      batchCfg = btc_cnt_cfg_t'(27'($random(seed)));
      batchCfg.scaleFactor = 20'({$random(seed)} % 1000000);
      totalCfg = btc_cnt_cfg_t'(27'($random(seed)));
      totalCfg.scaleFactor = 20'({$random(seed)} % 1000000);
      step(1);
      if (flowValid && !belowCutoff) expT += inc_of(flowValue, totalCfg);
      if (flowValid) expB += 48'(inc_of(flowValue, batchCfg));
      cmp();
      check(64'(batchDisp), 64'({batchCfg.prec, batchCfg.kiloUnits}));
      check(64'(totalDisp), 64'({totalCfg.prec, totalCfg.kiloUnits}));
    end
    flowValid = 1'h0;
    belowCutoff = 1'h0;
    for (int a = 8; a <= 16; a++) begin
      regRdAddr = 8'(a);
      step(1);
      check(64'(regRdData), 64'(word_of(a)));
    end
    for (int a = 8; a <= 16; a++) begin
      feed(1'h1, 1'h1);
      u_btc_host_model.write_word(8'(a), 16'h1);
      u_btc_host_model.write_word(8'(a), 16'h0);
      if (a >= 9 && a <= 12) expT = '0;
      if (a >= 13 && a <= 15) expB = '0;
      step(1);
      cmp();
    end
    for (int k = 0; k < 4; k++) begin
      feed(1'h1, 1'h1);
      if (k < 2) batchZeroAction = 1'h1;
      else totalZeroAction = 1'h1;
      step(1);
      {batchZeroAction, totalZeroAction} = '0;
      check(64'(confirmPrompt), 64'h1);
      if (k[0]) enterKey = 1'h1;
      else cancelKey = 1'h1;
      step(1);
      {enterKey, cancelKey} = '0;
      step(1);
      if (k == 1) expB = '0;
      if (k == 3) expT = '0;
      check(64'(confirmPrompt), 64'h0);
      cmp();
    end
    for (int m = 0; m < 4; m++) begin
      feed(1'h1, 1'h1);
      batchCfg.buttonZeroAllow = m[0];
      totalCfg.buttonZeroAllow = m[1];
      sumButton = 1'h1;
      step(1);
      sumButton = 1'h0;
      step(1);
      if (m[0]) expB = '0;
      if (m[1]) expT = '0;
      cmp();
    end
    ar_case(1'h1, 1'h0, 1);
    ar_case(1'h1, 1'h1, 0);
    ar_case(1'h0, 1'h0, 0);
    autoRestartEnable = 1'h0;
    inputAction = ACT_BATCH_ZERO;
    for (int t = 2; t < 4; t++) begin
      trigMode = btc_trig_t'(t);
      for (int v = 1; v >= 0; v--) begin
        feed(1'h1, 1'h1);
        s0 = starts;
        u_btc_host_model.drive_pin(1'(v), 8);
        if (v == 3 - t) expB = '0;
        cmp();
        check(64'(starts - s0), 64'(v == 3 - t));
      end
    end
    for (int a = 0; a < 4; a++) begin
      for (int h = 0; h < 2; h++) lvl_case(btc_action_t'(a), 1'(h));
    end
    inputAction = ACT_INHIBIT;
    trigMode = RISING_EDGE_TRIGGER;
    for (int e = 0; e < 4; e++) begin
      u_btc_host_model.drive_pin(1'h1, 8);
      feed(e[0], e[0]);
      cmp();
      u_btc_host_model.drive_pin(1'h0, 8);
    end
    complete_run();
  end

  // run should take about 1200 cycles
  initial begin
    #(25 * 6000);
    bad_count++;
    complete_run();
  end
endmodule : testbench
